/* hw/flow_frame_sampler_pkg.sv */
// constants and types shared by the frame sampler design
package flow_frame_sampler_pkg;
   localparam int PORT_COUNT = 8;
   localparam int PORT_ID_WIDTH = 3;
   localparam int PROBABILITY_WIDTH = 16;
   localparam int RANDOM_WIDTH = 15;
   localparam int QUEUE_SELECT_WIDTH = 3;
   localparam int COUNT_WIDTH = 32;
   localparam int STAMP_WIDTH = 32;
   localparam int STAMP_ID_POS = 28;
   localparam int STAMP_COUNT_WIDTH = 28;
   localparam int DIR_RX_BIT = 0;
   localparam int DIR_TX_BIT = 1;
   localparam int FLAG_COUNT = 3;
   localparam int FLAG_CAND_POS = 0;
   localparam int FLAG_SRC_POS = 1;
   localparam int FLAG_DST_POS = 2;
   localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 3'h0;
   localparam logic [31:0] LFSR_SEED = 32'h1d2c_3b4a;
   localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
   localparam logic [31:0] LFSR_SEED_STEP = 32'h9e37_79b9;
   localparam logic [PROBABILITY_WIDTH-1:0] PROBABILITY_FULL = 16'h8000;

   // one lfsr step, galois form
   function automatic logic [31:0] lfsr_step(input logic [31:0] value);
      lfsr_step = value[0] ? ((value >> 1) ^ LFSR_TAPS) : (value >> 1);
   endfunction : lfsr_step
endpackage : flow_frame_sampler_pkg

/* hw/sample_random_source.sv */
// free running random source, one per port sampler
`timescale 1ns/10ps
module sample_random_source
   import flow_frame_sampler_pkg::*;
#(
   parameter logic [31:0] SEED = LFSR_SEED
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // random value
   output logic [RANDOM_WIDTH-1:0] randomValue
);
   logic [31:0] state_reg;
   logic [31:0] state_next;

   // ==========================================================
   // advance every cycle so each candidate draws a fresh value
   always_comb begin
      state_next = lfsr_step(state_reg);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= SEED;
      end else begin
         state_reg <= state_next;
      end
   end

   assign randomValue = state_reg[RANDOM_WIDTH-1:0];
endmodule : sample_random_source

/* hw/sampler_decision.sv */
// probability comparison for one port sampler
`timescale 1ns/10ps
module sampler_decision
   import flow_frame_sampler_pkg::*;
(
   // compare inputs
   input wire logic [RANDOM_WIDTH-1:0] randomValue,
   input wire logic [PROBABILITY_WIDTH-1:0] probability,
   // decision
   output logic selectHit
);
   // ==========================================================
   // hit when random below probability, full scale always hits
   always_comb begin
      selectHit = ({1'b0, randomValue} < probability);
   end
endmodule : sampler_decision

/* hw/flow_frame_sampler.sv */
// per port statistical frame sampler with counters and debug flags
// Function
// - selected frame copied to chosen CPU queue
// - separate sampler, rate, direction per port
// - candidates sampled independently, except a tx frame with an rx candidate on the same port, drawn 0..16383 from that port's value
// - probability in steps of 1/32768
// - direction bit 0 enables received frames
// - direction bit 1 enables transmitted frames
// - receive and transmit controlled independently, same rate
// - port number in stamp when enabled
// - copy marked, check sequence replaced by stamp
// - sample counter counts copies sent
// - candidate counter counts every eligible frame
// - counts readable by software any time
// - sticky flags: candidate, source sample, destination sample
// - masked sticky events pulsed to port statistics
`timescale 1ns/10ps
module flow_frame_sampler
   import flow_frame_sampler_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // global configuration
   input wire logic samplingGlobalEnable,
   input wire logic samplerIdStampEnable,
   input wire logic [QUEUE_SELECT_WIDTH-1:0] sampleCpuQueueSelect,
   // per port sampler control, port p in slice p
   input wire logic [PORT_COUNT*PROBABILITY_WIDTH-1:0] samplingProbability,
   input wire logic [PORT_COUNT*2-1:0] candidateDirectionSelect,
   // frame events from forwarding, one pulse per frame
   input wire logic rxFrameValid,
   input wire logic [PORT_ID_WIDTH-1:0] rxFramePort,
   input wire logic txFrameValid,
   input wire logic [PORT_ID_WIDTH-1:0] txFramePort,
   // sticky flag clear and mask
   input wire logic [FLAG_COUNT-1:0] debugFlagsClear,
   input wire logic [FLAG_COUNT-1:0] debugFlagsMask,
   // count readback select
   input wire logic [PORT_ID_WIDTH-1:0] countReadPort,
   // copy requests to cpu extraction
   output logic rxCopyValid,
   output logic [QUEUE_SELECT_WIDTH-1:0] rxCopyQueue,
   output logic rxCopyMarker,
   output logic [STAMP_WIDTH-1:0] rxCopyStamp,
   output logic txCopyValid,
   output logic [QUEUE_SELECT_WIDTH-1:0] txCopyQueue,
   output logic txCopyMarker,
   output logic [STAMP_WIDTH-1:0] txCopyStamp,
   // counts and flags
   output logic [COUNT_WIDTH-1:0] samplesSentCount,
   output logic [COUNT_WIDTH-1:0] candidateFrameCount,
   output logic [FLAG_COUNT-1:0] debugEventFlags,
   output logic [FLAG_COUNT-1:0] portStatEvent
);
   // ==========================================================
   // per port random draw and decision
   logic [RANDOM_WIDTH-1:0] randomValue [PORT_COUNT];
   logic [PORT_COUNT-1:0] portHit;

   genvar gp;
   generate
      for (gp = 0; gp < PORT_COUNT; gp++) begin : gen_port
         sample_random_source #(
            .SEED(LFSR_SEED ^ (LFSR_SEED_STEP * (gp + 1)))
         ) u_random (
            .clock(clock),
            .rst(rst),
            .randomValue(randomValue[gp])
         );
         sampler_decision u_decision (
            .randomValue(randomValue[gp]),
            .probability(samplingProbability[gp*PROBABILITY_WIDTH +: PROBABILITY_WIDTH]),
            .selectHit(portHit[gp])
         );
      end
   endgenerate

   // ==========================================================
   // candidate qualification
   logic rxCand;
   logic txCand;
   logic rxSel;
   logic txSel;
   logic sameSel;
   logic [31:0] rxRandomSec;
   always_comb begin
      rxCand = samplingGlobalEnable && rxFrameValid
               && candidateDirectionSelect[rxFramePort*2 + DIR_RX_BIT];
      txCand = samplingGlobalEnable && txFrameValid
               && candidateDirectionSelect[txFramePort*2 + DIR_TX_BIT];
      rxSel = rxCand && portHit[rxFramePort];
      // second draw for a tx frame on the same port in the same cycle
      rxRandomSec = lfsr_step({17'h00000, randomValue[txFramePort]});
      sameSel = ({1'b0, rxRandomSec[RANDOM_WIDTH-1:0]}
                 < samplingProbability[txFramePort*PROBABILITY_WIDTH +: PROBABILITY_WIDTH]);
      if (rxCand && (rxFramePort == txFramePort)) begin
         txSel = txCand && sameSel;
      end else begin
         txSel = txCand && portHit[txFramePort];
      end
   end

   // ==========================================================
   // per port counters
   logic [COUNT_WIDTH-1:0] sentCount_reg [PORT_COUNT];
   logic [COUNT_WIDTH-1:0] sentCount_next [PORT_COUNT];
   logic [COUNT_WIDTH-1:0] candCount_reg [PORT_COUNT];
   logic [COUNT_WIDTH-1:0] candCount_next [PORT_COUNT];

   always_comb begin
      for (int p = 0; p < PORT_COUNT; p++) begin
         sentCount_next[p] = sentCount_reg[p]
            + COUNT_WIDTH'(rxSel && (rxFramePort == PORT_ID_WIDTH'(p)))
            + COUNT_WIDTH'(txSel && (txFramePort == PORT_ID_WIDTH'(p)));
         candCount_next[p] = candCount_reg[p]
            + COUNT_WIDTH'(rxCand && (rxFramePort == PORT_ID_WIDTH'(p)))
            + COUNT_WIDTH'(txCand && (txFramePort == PORT_ID_WIDTH'(p)));
      end
   end

   always_ff @(posedge clock) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
         if (rst) begin
            sentCount_reg[p] <= COUNT_RESET;
            candCount_reg[p] <= COUNT_RESET;
         end else begin
            sentCount_reg[p] <= sentCount_next[p];
            candCount_reg[p] <= candCount_next[p];
         end
      end
   end

   // ==========================================================
   // stamp building, count taken after this sample is counted
   function automatic logic [STAMP_WIDTH-1:0] make_stamp(
      input logic [COUNT_WIDTH-1:0] count,
      input logic [PORT_ID_WIDTH-1:0] port,
      input logic withId
   );
      logic [STAMP_WIDTH-1:0] stamp;
      stamp = count[STAMP_WIDTH-1:0];
      if (withId) begin
         stamp[STAMP_WIDTH-1:STAMP_ID_POS] = {1'b0, port};
         stamp[STAMP_COUNT_WIDTH-1:0] = count[STAMP_COUNT_WIDTH-1:0];
      end
      make_stamp = stamp;
   endfunction : make_stamp

   // ==========================================================
   // copy outputs and flags
   logic rxCopyValid_reg;
   logic rxCopyValid_next;
   logic [QUEUE_SELECT_WIDTH-1:0] rxCopyQueue_reg;
   logic [QUEUE_SELECT_WIDTH-1:0] rxCopyQueue_next;
   logic [STAMP_WIDTH-1:0] rxCopyStamp_reg;
   logic [STAMP_WIDTH-1:0] rxCopyStamp_next;
   logic txCopyValid_reg;
   logic txCopyValid_next;
   logic [QUEUE_SELECT_WIDTH-1:0] txCopyQueue_reg;
   logic [QUEUE_SELECT_WIDTH-1:0] txCopyQueue_next;
   logic [STAMP_WIDTH-1:0] txCopyStamp_reg;
   logic [STAMP_WIDTH-1:0] txCopyStamp_next;
   logic [FLAG_COUNT-1:0] flags_reg;
   logic [FLAG_COUNT-1:0] flags_next;
   logic [FLAG_COUNT-1:0] flagEvent;
   logic [FLAG_COUNT-1:0] statEvent_reg;
   logic [FLAG_COUNT-1:0] statEvent_next;
   logic [COUNT_WIDTH-1:0] readSent_reg;
   logic [COUNT_WIDTH-1:0] readSent_next;
   logic [COUNT_WIDTH-1:0] readCand_reg;
   logic [COUNT_WIDTH-1:0] readCand_next;
   logic [COUNT_WIDTH-1:0] txCountBase;

   always_comb begin
      rxCopyValid_next = rxSel;
      rxCopyQueue_next = sampleCpuQueueSelect;
      rxCopyStamp_next = make_stamp(sentCount_reg[rxFramePort] + COUNT_WIDTH'(1),
                                    rxFramePort, samplerIdStampEnable);
      txCopyValid_next = txSel;
      txCopyQueue_next = sampleCpuQueueSelect;
      txCountBase = sentCount_reg[txFramePort]
                    + COUNT_WIDTH'(rxSel && (rxFramePort == txFramePort));
      txCopyStamp_next = make_stamp(txCountBase + COUNT_WIDTH'(1),
                                    txFramePort, samplerIdStampEnable);
      flagEvent = '0;
      flagEvent[FLAG_CAND_POS] = rxCand || txCand;
      flagEvent[FLAG_SRC_POS] = rxSel;
      flagEvent[FLAG_DST_POS] = txSel;
      // set wins over a clear in the same cycle
      flags_next = (flags_reg & ~debugFlagsClear) | flagEvent;
      statEvent_next = flagEvent & debugFlagsMask;
      readSent_next = sentCount_reg[countReadPort];
      readCand_next = candCount_reg[countReadPort];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rxCopyValid_reg <= 1'b0;
         rxCopyQueue_reg <= '0;
         rxCopyStamp_reg <= '0;
         txCopyValid_reg <= 1'b0;
         txCopyQueue_reg <= '0;
         txCopyStamp_reg <= '0;
         flags_reg <= FLAGS_RESET;
         statEvent_reg <= '0;
         readSent_reg <= COUNT_RESET;
         readCand_reg <= COUNT_RESET;
      end else begin
         rxCopyValid_reg <= rxCopyValid_next;
         rxCopyQueue_reg <= rxCopyQueue_next;
         rxCopyStamp_reg <= rxCopyStamp_next;
         txCopyValid_reg <= txCopyValid_next;
         txCopyQueue_reg <= txCopyQueue_next;
         txCopyStamp_reg <= txCopyStamp_next;
         flags_reg <= flags_next;
         statEvent_reg <= statEvent_next;
         readSent_reg <= readSent_next;
         readCand_reg <= readCand_next;
      end
   end

   // ==========================================================
   // output assignment
   assign rxCopyValid = rxCopyValid_reg;
   assign rxCopyQueue = rxCopyQueue_reg;
   assign rxCopyMarker = rxCopyValid_reg;
   assign rxCopyStamp = rxCopyStamp_reg;
   assign txCopyValid = txCopyValid_reg;
   assign txCopyQueue = txCopyQueue_reg;
   assign txCopyMarker = txCopyValid_reg;
   assign txCopyStamp = txCopyStamp_reg;
   assign samplesSentCount = readSent_reg;
   assign candidateFrameCount = readCand_reg;
   assign debugEventFlags = flags_reg;
   assign portStatEvent = statEvent_reg;
endmodule : flow_frame_sampler

/* sim/flow_frame_sampler_chk.sv */
// port checker for the frame sampler
`timescale 1ns/10ps
module flow_frame_sampler_chk (
   // watched ports
   input wire logic clock,
   input wire logic rst,
   input wire logic samplingGlobalEnable,
   input wire logic samplerIdStampEnable,
   input wire logic [2:0] sampleCpuQueueSelect,
   input wire logic [15:0] candidateDirectionSelect,
   input wire logic rxFrameValid,
   input wire logic [2:0] rxFramePort,
   input wire logic txFrameValid,
   input wire logic [2:0] txFramePort,
   input wire logic [2:0] debugFlagsClear,
   input wire logic [2:0] debugFlagsMask,
   input wire logic rxCopyValid,
   input wire logic [2:0] rxCopyQueue,
   input wire logic rxCopyMarker,
   input wire logic [31:0] rxCopyStamp,
   input wire logic txCopyValid,
   input wire logic txCopyMarker,
   input wire logic [2:0] debugEventFlags,
   input wire logic [2:0] portStatEvent
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========
   // port relations
   sequence s_rxTaken;
      rxFrameValid && samplingGlobalEnable && candidateDirectionSelect[2*rxFramePort];
   endsequence
   property p_queue; rxCopyValid |-> rxCopyQueue == $past(sampleCpuQueueSelect); endproperty
   a_queue: assert property (p_queue) else $error("copy queue wrong");
   property p_mark; rxCopyValid == rxCopyMarker && txCopyValid == txCopyMarker; endproperty
   a_mark: assert property (p_mark) else $error("marker wrong");
   property p_rxCause; rxCopyValid |-> $past(rxFrameValid && samplingGlobalEnable &&
      candidateDirectionSelect[2*rxFramePort]); endproperty
   a_rxCause: assert property (p_rxCause) else $error("rx copy without candidate");
   property p_txCause; txCopyValid |-> $past(txFrameValid && samplingGlobalEnable &&
      candidateDirectionSelect[2*txFramePort+1]); endproperty
   a_txCause: assert property (p_txCause) else $error("tx copy without candidate");
   property p_id; rxCopyValid && $past(samplerIdStampEnable) |-> rxCopyStamp[31:28] == {1'b0, $past(rxFramePort)};
   endproperty
   a_id: assert property (p_id) else $error("stamp id wrong");
   property p_src; rxCopyValid |-> debugEventFlags[1] && portStatEvent[1] == $past(debugFlagsMask[1]); endproperty
   a_src: assert property (p_src) else $error("source flag or event wrong");
   property p_cand; s_rxTaken |=> debugEventFlags[0] && portStatEvent[0] == $past(debugFlagsMask[0]); endproperty
   a_cand: assert property (p_cand) else $error("candidate flag or event wrong");
   property p_sticky; debugEventFlags[2] && !debugFlagsClear[2] |=> debugEventFlags[2]; endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost without clear");
endmodule : flow_frame_sampler_chk
bind flow_frame_sampler flow_frame_sampler_chk u_chk (.*);

/* sim/cpu_extract_model.sv */
// cpu extraction side model counting marked rx copy requests
`timescale 1ns/10ps
module cpu_extract_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // copy requests, never stalled
   input wire logic rxCopyValid,
   input wire logic rxCopyMarker,
   output logic [31:0] rxTaken
);
   // only marked copies are taken as samples
   always_ff @(posedge clock) begin
      if (rst)
         rxTaken <= 32'h0;
      else
         rxTaken <= rxTaken + 32'(rxCopyValid & rxCopyMarker);
   end
endmodule : cpu_extract_model

/* sim/flow_frame_sampler_tb.sv */
// self-checking bench for the frame sampler
`timescale 1ns/10ps
module flow_frame_sampler_tb;
   import flow_frame_sampler_pkg::*;
   // io: rx frame, tx frame, rx copy expected, tx copy expected
   typedef struct {logic [2:0] p; logic [1:0] dir; logic [15:0] pr; logic [3:0] io;} row_t;
   row_t rows [8] = '{'{3'h0, 2'h1, 16'h8000, 4'ha}, '{3'h1, 2'h2, 16'h8000, 4'h5}, '{3'h2, 2'h2, 16'h8000, 4'h8},
      '{3'h3, 2'h1, 16'h8000, 4'h4}, '{3'h4, 2'h3, 16'hffff, 4'hf}, '{3'h5, 2'h3, 16'h0000, 4'h8},
      '{3'h6, 2'h3, 16'h8000, 4'ha}, '{3'h7, 2'h0, 16'h8000, 4'hc}};
   logic clock = 1'b0, rst = 1'b1, samplingGlobalEnable = 1'b1, samplerIdStampEnable = 1'b0;
   logic rxFrameValid = 1'b0, txFrameValid = 1'b0, rxCopyValid, rxCopyMarker, txCopyValid, txCopyMarker;
   logic [2:0] sampleCpuQueueSelect = 3'h0, rxFramePort = 3'h0, txFramePort = 3'h0, debugFlagsClear = 3'h0;
   logic [2:0] debugFlagsMask = 3'h5, countReadPort = 3'h0, rxCopyQueue, txCopyQueue, debugEventFlags, portStatEvent;
   logic [127:0] samplingProbability = 128'h0;
   logic [15:0] candidateDirectionSelect = 16'h0;
   logic [31:0] rxCopyStamp, txCopyStamp, samplesSentCount, candidateFrameCount, rxTaken, base;
   logic [31:0] sent [8] = '{default: 32'h0};
   logic [31:0] seen [8] = '{default: 32'h0};
   int error_cnt = 0, n_checks = 0, cyc = 0, i;
   // ==========
   // design, cpu side and clock
   flow_frame_sampler u_dut (.*);
   cpu_extract_model u_cpu (.*);
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end
   // ==========
   // helpers
   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   function automatic logic [31:0] stamp(input logic [2:0] p, input logic [31:0] c);
      stamp = samplerIdStampEnable ? {1'b0, p, c[27:0]} : c;
   endfunction : stamp
   task clr(input logic [2:0] v);
      @(posedge clock);
      debugFlagsClear <= v;
      @(posedge clock);
      debugFlagsClear <= 3'h0;
      #1;
   endtask : clr
   task frameChk(input logic r, input logic t, input logic [2:0] p, input logic er, input logic et);
      logic [1:0] d;
      logic c;
      d = candidateDirectionSelect[2*p +: 2];
      c = samplingGlobalEnable & ((r & d[0]) | (t & d[1]));
      @(posedge clock);
      rxFrameValid <= r;
      txFrameValid <= t;
      rxFramePort <= p;
      txFramePort <= p;
      @(posedge clock);
      rxFrameValid <= 1'b0;
      txFrameValid <= 1'b0;
      countReadPort <= p;
      #1;
      seen[p] = seen[p] + 32'(samplingGlobalEnable & r & d[0]) + 32'(samplingGlobalEnable & t & d[1]);
      chk(rxCopyValid === er && txCopyValid === et, "copy request");
      sent[p] = sent[p] + 32'(er);
      chk(!er || {rxCopyQueue, rxCopyMarker, rxCopyStamp} === {sampleCpuQueueSelect, 1'b1, stamp(p, sent[p])}, "rx copy");
      sent[p] = sent[p] + 32'(et);
      chk(!et || {txCopyQueue, txCopyMarker, txCopyStamp} === {sampleCpuQueueSelect, 1'b1, stamp(p, sent[p])}, "tx copy");
      chk(portStatEvent === ({et, er, c} & debugFlagsMask), "stat event");
      @(posedge clock);
      #1;
      chk({samplesSentCount, candidateFrameCount} === {sent[p], seen[p]}, "counts");
   endtask : frameChk
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // ==========
   // tests
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(posedge clock);
         samplingProbability[16*rows[i].p +: 16] <= rows[i].pr;
         candidateDirectionSelect[2*rows[i].p +: 2] <= rows[i].dir;
         sampleCpuQueueSelect <= i[2:0];
         #1;
         frameChk(rows[i].io[3], rows[i].io[2], rows[i].p, rows[i].io[1], rows[i].io[0]);
      end
      $display("table rows done");
      chk(debugEventFlags === 3'h7, "flags set");
      clr(3'h2);
      chk(debugEventFlags === 3'h5, "one flag cleared");
      clr(3'h5);
      chk(debugEventFlags === 3'h0, "flags cleared");
      @(posedge clock);
      samplingGlobalEnable <= 1'b0;
      debugFlagsMask <= 3'h7;
      #1;
      frameChk(1'b1, 1'b1, 3'h4, 1'b0, 1'b0);
      chk(debugEventFlags === 3'h0, "flags while off");
      @(posedge clock);
      samplingGlobalEnable <= 1'b1;
      samplerIdStampEnable <= 1'b1;
      #1;
      frameChk(1'b1, 1'b1, 3'h4, 1'b1, 1'b1);
      $display("flags, enable and stamp done");
      @(posedge clock);
      samplingProbability[15:0] <= 16'h4000;
      base <= rxTaken;
      rxFrameValid <= 1'b1;
      rxFramePort <= 3'h0;
      countReadPort <= 3'h0;
      repeat (256) @(posedge clock);
      rxFrameValid <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      base = rxTaken - base;
      chk(candidateFrameCount === seen[0] + 32'h100, "candidates");
      chk(samplesSentCount === sent[0] + base, "samples");
      chk(base > 32'h60 && base < 32'ha0, "sample ratio");
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk({samplesSentCount, candidateFrameCount, debugEventFlags, rxCopyValid, txCopyValid} ===
         {COUNT_RESET, COUNT_RESET, FLAGS_RESET, 2'h0}, "reset values");
      $display("statistics and reset done");
      summarize();
   end
endmodule : flow_frame_sampler_tb
